// >>> pkg/rwc_pkg.sv
// Shared constants, types and carriers of the disc read/write data channel.
// Assumes one 50 MHz clock, AXI4-Lite register access and pins sampled by rwc_sync.
// Operation
// - Only heads 00 to 18 are selectable.
// - Odd heads left bank, even heads right.
// - Selected head gets centre tap; servo tap always.
// - One servo pulse per interval, 13440 per turn.
// - Encode write data as MFM with precompensation.
// - Write trigger flips coil current per transition.
// - Recovered clock phase-locks to raw read pulses.
// - Separator drops clock pulses, keeps data pulses.
// - Read strobe comes from recovered clock, per bit.
// - Read data and strobe only during read.
// - Head select bit zero picks the bank.
// - Upper head bits decode onto ten taps.
// - Read needs ready, command, amp on, no inoperate.
package rwc_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_SERVO = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int HEAD_W = 5;
  localparam int NUM_CT = 10;
  localparam logic [HEAD_W-1:0] HEAD_MAX = 5'h12;
  localparam int CTRL_HEAD_LSB = 0;
  localparam int CTRL_HSEL_EN = 8;
  localparam int CTRL_DEFEAT = 9;
  localparam int CTRL_INOP_CLR = 16;
  localparam int LANE_HEAD = 0;
  localparam int LANE_FLAGS = 1;
  localparam int LANE_CLR = 2;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_INOP = 2;
  localparam int STAT_HEAD_OK = 3;
  localparam int STAT_EMPTY = 4;
  localparam int STAT_FULL = 5;
  localparam int CLK_NS = 20;
  localparam int SERVO_INTERVAL_NS = 1240;
  localparam int SERVO_INTERVAL_CYC = SERVO_INTERVAL_NS / CLK_NS;
  localparam int SERVO_PER_REV = 13440;
  localparam int SRV_DIV_W = 6;
  localparam int SRV_CNT_W = 14;
  localparam logic [SRV_DIV_W-1:0] SRV_DIV_LAST = SRV_DIV_W'(SERVO_INTERVAL_CYC - 1);
  localparam logic [SRV_CNT_W-1:0] SRV_CNT_LAST = SRV_CNT_W'(SERVO_PER_REV - 1);
  // The cell counter wraps by overflow, so a cell must stay a power of two in cycles.
  localparam int CELL_NS = 160;
  localparam int CELL_CYC = CELL_NS / CLK_NS;
  localparam int PH_W = 3;
  localparam logic [PH_W-1:0] PH_ZERO = 3'h0;
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(CELL_CYC / 2);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CELL_CYC - 1);
  localparam logic [PH_W-1:0] DWIN_LO = 3'h2;
  localparam logic [PH_W-1:0] DWIN_HI = 3'h5;
  localparam logic [PH_W-1:0] PH_HOLD = 3'h0;
  localparam logic [PH_W-1:0] PH_NOM = 3'h1;
  localparam logic [PH_W-1:0] PH_ADV = 3'h2;
  localparam int PRE_W = 2;
  localparam int PRE_EARLY_NS = 20;
  localparam int PRE_NOM_NS = 40;
  localparam int PRE_LATE_NS = 60;
  localparam logic [PRE_W-1:0] PRE_ONE = 2'h1;
  localparam logic [PRE_W-1:0] PRE_EARLY = PRE_W'(PRE_EARLY_NS / CLK_NS);
  localparam logic [PRE_W-1:0] PRE_NOM = PRE_W'(PRE_NOM_NS / CLK_NS);
  localparam logic [PRE_W-1:0] PRE_LATE = PRE_W'(PRE_LATE_NS / CLK_NS);
  localparam int FIFO_DEPTH_DEF = 16;

  typedef enum logic [1:0] {
    RWC_IDLE = 2'b00,
    RWC_READ = 2'b01,
    RWC_WRITE = 2'b10
  } rwc_mode_e;

  typedef struct packed {
    logic write_cmd;
    logic read_cmd;
    logic wr_nrz;
    logic wr_strobe;
  } rwc_ctl_in_s;

  typedef struct packed {
    logic rd_data;
    logic rd_strobe;
    logic servo_pulse;
    logic rev_index;
  } rwc_ctl_out_s;

  typedef struct packed {
    logic [NUM_CT-1:0] ct_sel;
    logic servo_ct;
    logic read_left;
    logic read_right;
    logic write_left;
    logic write_right;
    logic write_coil;
  } rwc_head_s;
endpackage : rwc_pkg

// >>> core/rwc_sync.sv
// Three-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes each input level holds for at least three clock cycles.
`timescale 1ns/1ns
`default_nettype none
module rwc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);
  import rwc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } rwc_sync_s;

  rwc_sync_s st_reg;
  rwc_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // A bit moves only once the second and third stages agree, so one glitch cannot pass.
    st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
endmodule : rwc_sync
`default_nettype wire

// >>> core/rwc_fifo.sv
// Small first-in first-out buffer with a registered output word.
// Assumes DEPTH is a power of two; both sides use valid and ready on aclk.
`timescale 1ns/1ns
`default_nettype none
module rwc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import rwc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } rwc_fifo_s;

  rwc_fifo_s st_reg;
  rwc_fifo_s st_next;
  logic push;
  logic load;

  assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  // The output word refills as it is taken, so a steady reader sees no bubble.
  assign load = (st_reg.cnt != '0) && (!st_reg.ov || out_ready);

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (st_reg.ov && out_ready) begin
      st_next.ov = 1'b0;
    end
    if (load) begin
      st_next.od = st_reg.mem[st_reg.rptr];
      st_next.ov = 1'b1;
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.ov;
  assign out_data = st_reg.od;
endmodule : rwc_fifo
`default_nettype wire

// >>> core/rwc_channel.sv
// Read/write data channel: head select, servo pulses, MFM write encoder and read separator.
// Assumes controller pins and raw read pulses are asynchronous and registers sit on AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module rwc_channel #(
  parameter int FIFO_DEPTH = rwc_pkg::FIFO_DEPTH_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rwc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rwc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rwc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rwc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rwc_pkg::rwc_ctl_in_s ctl_in,
  output var rwc_pkg::rwc_ctl_out_s ctl_out,
  input wire logic raw_mfm,
  input wire logic drive_ready,
  input wire logic lin_amp_on,
  output var rwc_pkg::rwc_head_s head_out
);
  import rwc_pkg::*;
  localparam int SYNC_W = 5;
  localparam int SRV_P = SERVO_INTERVAL_CYC;

  typedef struct packed {
    rwc_mode_e mode;
    logic inop;
    logic defeat;
    logic hsel_en;
    logic [HEAD_W-1:0] head_sel;
    logic aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [SRV_DIV_W-1:0] srv_div;
    logic [SRV_CNT_W-1:0] srv_cnt;
    logic strobe_d;
    logic raw_d;
    logic [PH_W-1:0] ph;
    logic prev;
    logic cur;
    logic nxt;
    logic trig;
    logic [PRE_W-1:0] pend;
    logic data_seen;
    rwc_ctl_out_s ctl;
    rwc_head_s hout;
  } rwc_chan_s;

  rwc_chan_s st_reg;
  rwc_chan_s st_next;
  logic [SYNC_W-1:0] sync_lvl;
  rwc_ctl_in_s cmd;
  logic raw_lvl;
  logic head_ok;
  logic rd_ok;
  logic wr_ok;
  logic strobe_rise;
  logic raw_edge;
  logic tap_en;
  logic [NUM_CT-1:0] tap_onehot;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [0:0] fifo_out_data;

  rwc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({raw_mfm, ctl_in}),
    .level_out(sync_lvl)
  );

  assign cmd = rwc_ctl_in_s'(sync_lvl[SYNC_W-2:0]);
  assign raw_lvl = sync_lvl[SYNC_W-1];
  assign strobe_rise = cmd.wr_strobe && !st_reg.strobe_d;
  assign raw_edge = raw_lvl && !st_reg.raw_d;

  assign head_ok = st_reg.hsel_en && (st_reg.head_sel <= HEAD_MAX);
  assign rd_ok = drive_ready && cmd.read_cmd && lin_amp_on && !cmd.write_cmd && !st_reg.inop && head_ok;
  assign wr_ok = drive_ready && cmd.write_cmd && lin_amp_on && !cmd.read_cmd && !st_reg.inop && head_ok;

  // The strobe cannot be held off, so a full buffer drops the bit and raises the inoperate latch.
  assign fifo_in_valid = (st_reg.mode == RWC_WRITE) && strobe_rise;
  assign fifo_out_ready = (st_reg.mode == RWC_WRITE) && (st_reg.ph == PH_LAST);

  rwc_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(cmd.wr_nrz),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign tap_en = head_ok && !st_reg.defeat && (st_reg.mode != RWC_IDLE);
  for (genvar i = 0; i < NUM_CT; i++) begin : g_ct
    assign tap_onehot[i] = tap_en && (st_reg.head_sel[HEAD_W-1:1] == (HEAD_W-1)'(i));
  end

  always_comb begin
    logic wrap;
    logic [PH_W-1:0] step;
    wrap = 1'b0;
    step = PH_NOM;
    st_next = st_reg;
    st_next.strobe_d = cmd.wr_strobe;
    st_next.raw_d = raw_lvl;

    case (st_reg.mode)
      RWC_IDLE: begin
        if (wr_ok) begin
          st_next.mode = RWC_WRITE;
        end else if (rd_ok) begin
          st_next.mode = RWC_READ;
        end
      end
      RWC_READ: begin
        if (!rd_ok) begin
          st_next.mode = RWC_IDLE;
        end
      end
      RWC_WRITE: begin
        if (!wr_ok) begin
          st_next.mode = RWC_IDLE;
        end
      end
      default: begin
        st_next.mode = RWC_IDLE;
      end
    endcase

    if (st_reg.mode == RWC_WRITE) begin
      st_next.ph = st_reg.ph + PH_NOM;
      if (st_reg.pend != '0) begin
        st_next.pend = st_reg.pend - PRE_ONE;
      end
      if (st_reg.pend == PRE_ONE) begin
        st_next.trig = !st_reg.trig;
      end
      if (st_reg.ph == PH_LAST) begin
        st_next.prev = st_reg.cur;
        st_next.cur = st_reg.nxt;
        // An empty buffer pads zeros so the encoder keeps writing clock transitions.
        st_next.nxt = fifo_out_valid && fifo_out_data[0];
      end
      if (st_reg.ph == PH_ZERO && !st_reg.prev && !st_reg.cur) begin
        st_next.pend = PRE_NOM;
      end
      if (st_reg.ph == PH_HALF && st_reg.cur) begin
        if (st_reg.prev && !st_reg.nxt) begin
          st_next.pend = PRE_LATE;
        end else if (!st_reg.prev && st_reg.nxt) begin
          st_next.pend = PRE_EARLY;
        end else begin
          st_next.pend = PRE_NOM;
        end
      end
    end else if (st_reg.mode == RWC_READ) begin
      if (raw_edge) begin
        if (st_reg.ph >= DWIN_LO && st_reg.ph <= DWIN_HI) begin
          st_next.data_seen = 1'b1;
          step = (st_reg.ph < PH_HALF) ? PH_ADV : ((st_reg.ph > PH_HALF) ? PH_HOLD : PH_NOM);
        end else begin
          step = (st_reg.ph == PH_ZERO) ? PH_NOM : ((st_reg.ph > DWIN_HI) ? PH_ADV : PH_HOLD);
        end
      end
      st_next.ph = st_reg.ph + step;
      wrap = st_next.ph < st_reg.ph;
      if (wrap) begin
        st_next.ctl.rd_data = st_reg.data_seen;
        st_next.data_seen = 1'b0;
      end
    end else begin
      st_next.ph = PH_ZERO;
      st_next.prev = 1'b0;
      st_next.cur = 1'b0;
      st_next.nxt = 1'b0;
      st_next.pend = '0;
      st_next.data_seen = 1'b0;
    end
    if (st_next.mode != RWC_READ) begin
      st_next.ctl.rd_data = 1'b0;
    end
    st_next.ctl.rd_strobe = (st_next.mode == RWC_READ) && (st_next.ph < PH_HALF);

    if (st_reg.srv_div == SRV_DIV_LAST) begin
      st_next.srv_div = '0;
      st_next.ctl.servo_pulse = 1'b1;
      st_next.ctl.rev_index = st_reg.srv_cnt == SRV_CNT_LAST;
      st_next.srv_cnt = (st_reg.srv_cnt == SRV_CNT_LAST) ? '0 : st_reg.srv_cnt + 1'b1;
    end else begin
      st_next.srv_div = st_reg.srv_div + 1'b1;
      st_next.ctl.servo_pulse = 1'b0;
      st_next.ctl.rev_index = 1'b0;
    end

    st_next.hout.ct_sel = tap_onehot;
    st_next.hout.servo_ct = 1'b1;
    st_next.hout.read_left = (st_reg.mode == RWC_READ) && st_reg.head_sel[0];
    st_next.hout.read_right = (st_reg.mode == RWC_READ) && !st_reg.head_sel[0];
    st_next.hout.write_left = (st_reg.mode == RWC_WRITE) && st_reg.head_sel[0];
    st_next.hout.write_right = (st_reg.mode == RWC_WRITE) && !st_reg.head_sel[0];
    st_next.hout.write_coil = st_reg.trig;

    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr)
        REG_CTRL: begin
          if (st_reg.wstrb[LANE_HEAD]) begin
            st_next.head_sel = st_reg.wdata[CTRL_HEAD_LSB +: HEAD_W];
          end
          if (st_reg.wstrb[LANE_FLAGS]) begin
            st_next.hsel_en = st_reg.wdata[CTRL_HSEL_EN];
            st_next.defeat = st_reg.wdata[CTRL_DEFEAT];
          end
          if (st_reg.wstrb[LANE_CLR] && st_reg.wdata[CTRL_INOP_CLR]) begin
            st_next.inop = 1'b0;
          end
        end
        REG_STATUS, REG_SERVO: begin
          st_next.bresp = RESP_OKAY;
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Placed after the clear so that a fault in the clearing cycle still latches.
    if ((cmd.read_cmd && cmd.write_cmd) || (fifo_in_valid && !fifo_in_ready)) begin
      st_next.inop = 1'b1;
    end

    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      case (s_axi_araddr)
        REG_CTRL: begin
          st_next.rdata[CTRL_HEAD_LSB +: HEAD_W] = st_reg.head_sel;
          st_next.rdata[CTRL_HSEL_EN] = st_reg.hsel_en;
          st_next.rdata[CTRL_DEFEAT] = st_reg.defeat;
        end
        REG_STATUS: begin
          st_next.rdata[STAT_MODE_LSB +: 2] = st_reg.mode;
          st_next.rdata[STAT_INOP] = st_reg.inop;
          st_next.rdata[STAT_HEAD_OK] = head_ok;
          st_next.rdata[STAT_EMPTY] = !fifo_out_valid;
          st_next.rdata[STAT_FULL] = !fifo_in_ready;
        end
        REG_SERVO: begin
          st_next.rdata[SRV_CNT_W-1:0] = st_reg.srv_cnt;
        end
        default: begin
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign ctl_out = st_reg.ctl;

  always_comb begin
    head_out = st_reg.hout;
    head_out.servo_ct = 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  head_range_a: assert property (head_out.ct_sel != '0 |-> $past(st_reg.head_sel) <= HEAD_MAX)
    else $error("tap driven for a head above 18");
  bank_left_a: assert property (head_out.read_left |-> $past(st_reg.head_sel[0]) && !head_out.read_right)
    else $error("left bank chosen for an even head");
  bank_right_a: assert property (head_out.read_right |-> !$past(st_reg.head_sel[0]))
    else $error("right bank chosen for an odd head");
  tap_active_a: assert property (head_out.ct_sel != '0 |-> $past(st_reg.mode) != RWC_IDLE && head_out.servo_ct)
    else $error("tap driven with no transfer under way");
  tap_decode_a: assert property (head_out.ct_sel != '0 |-> !$past(st_reg.defeat) && $onehot(head_out.ct_sel))
    else $error("tap decode not one-hot or not inhibited");
  servo_period_a: assert property (ctl_out.servo_pulse |-> ##SRV_P ctl_out.servo_pulse)
    else $error("servo pulse spacing wrong");
  servo_gap_a: assert property (ctl_out.servo_pulse |=> !ctl_out.servo_pulse [*8])
    else $error("servo pulse repeated too soon");
  rev_pulse_a: assert property (ctl_out.rev_index |-> ctl_out.servo_pulse)
    else $error("revolution index away from a servo pulse");
  precomp_late_a: assert property ((st_reg.mode == RWC_WRITE && st_reg.ph == PH_HALF && st_reg.cur
    && st_reg.prev && !st_reg.nxt) |=> st_reg.pend == PRE_LATE) else $error("late precompensation missing");
  trig_toggle_a: assert property ($changed(st_reg.trig) |-> $past(st_reg.pend) == PRE_ONE)
    else $error("write trigger flipped without a due transition");
  zero_pair_a: assert property ((st_reg.mode == RWC_WRITE && wr_ok && st_reg.ph == PH_ZERO
    && (st_reg.prev || st_reg.cur)) |=> st_reg.pend == '0) else $error("boundary transition next to a one");
  pll_advance_a: assert property ((st_reg.mode == RWC_READ && rd_ok && raw_edge && st_reg.ph >= DWIN_LO
    && st_reg.ph < PH_HALF) |=> st_reg.ph == $past(st_reg.ph) + PH_ADV) else $error("early pulse not advanced");
  clock_strip_a: assert property ((st_reg.mode == RWC_READ && rd_ok && raw_edge && st_reg.ph > DWIN_HI
    && !st_reg.data_seen) |=> !st_reg.data_seen) else $error("clock pulse taken as data");
  strobe_align_a: assert property (($rose(ctl_out.rd_strobe) && $past(st_reg.mode) == RWC_READ)
    |-> $past(st_reg.ph) >= PH_HALF) else $error("read strobe not at a cell boundary");
  read_gate_a: assert property ((ctl_out.rd_strobe || ctl_out.rd_data) |-> st_reg.mode == RWC_READ)
    else $error("read outputs active outside a read");
  read_start_a: assert property ($rose(st_reg.mode == RWC_READ) |-> $past(rd_ok))
    else $error("read started without its conditions");

  read_seen_c: cover property ($rose(st_reg.mode == RWC_READ) ##[1:200] ctl_out.rd_data);
  write_seen_c: cover property ($rose(st_reg.mode == RWC_WRITE) ##[1:200] $changed(st_reg.trig));
  rev_index_c: cover property (ctl_out.rev_index);
  inop_seen_c: cover property ($rose(st_reg.inop));
endmodule : rwc_channel
`default_nettype wire

// >>> verification/rwc_ctl_model.sv
// Controller model: write command, NRZ level and strobes, read command, raw read pulses.
// Assumes aclk is the bench clock; one 160 ns cell is eight of its cycles.
`timescale 1ns/1ns
`default_nettype none
module rwc_ctl_model
  import rwc_pkg::*;
(
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic rd_en,
  output var rwc_ctl_in_s ctl,
  output logic raw
);
  logic [2:0] ph = 3'h0;
  logic [4:0] rp = 5'h00;
  rwc_ctl_in_s c = '0;
  logic p = 1'b0;
  assign ctl = c;
  assign raw = p;
  always_ff @(posedge aclk) begin
    ph <= ph + 3'h1;
    rp <= (rp == 5'h17) ? 5'h00 : rp + 5'h01;
    c.write_cmd <= wr_en;
    c.read_cmd <= rd_en;
    // The strobe stands still between frames; the idle NRZ line toggles so stale data shows.
    c.wr_nrz <= wr_en ? 1'b1 : ~c.wr_nrz;
    c.wr_strobe <= wr_en && ph < 3'h4;
    // Pulses every 12 cycles spell the bits 1, 0, 0 over and over: a mid-cell pulse, then a clock pulse.
    // Either lock of the recovered clock then yields exactly one set bit in every three cells.
    p <= rd_en && (rp < 5'h04 || (rp >= 5'h0C && rp < 5'h10));
  end
endmodule : rwc_ctl_model
`default_nettype wire

// >>> verification/tb_rwc_channel.sv
// Self-checking bench for the read/write data channel.
// Assumes a 50 MHz aclk and registers reached over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module tb_rwc_channel;
  import rwc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, raw, c;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic wr_en = 1'b0, rd_en = 1'b0, rdy = 1'b0, amp = 1'b0;
  rwc_ctl_in_s ctl;
  rwc_ctl_out_s co;
  rwc_head_s ho;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  int m;
  rwc_channel #(.FIFO_DEPTH(16)) rwc_channel_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctl_in(ctl), .ctl_out(co), .raw_mfm(raw), .drive_ready(rdy), .lin_amp_on(amp), .head_out(ho));
  rwc_ctl_model rwc_ctl_model_i (.aclk(aclk), .wr_en(wr_en), .rd_en(rd_en), .ctl(ctl), .raw(raw));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  task axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task t_servo;
    n = 0;
    while (co.servo_pulse !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (co.servo_pulse !== 1'b1 && n < 200);
    chk("servo_gap", 32'(n), 32'(SERVO_INTERVAL_CYC));
  endtask : t_servo
  task t_regs;
    axw(REG_CTRL, 32'h0000_0113);
    chk("wr_resp", r, RESP_OKAY);
    axr(REG_STATUS);
    chk("head19_ok", d[STAT_HEAD_OK], 32'h0);
    axw(REG_CTRL, 32'h0000_0112);
    axr(REG_STATUS);
    chk("head18_ok", d[STAT_HEAD_OK], 32'h1);
    axr(8'h0C);
    chk("bad_resp", r, RESP_SLVERR);
    chk("bad_data", d, 32'h0);
    axw(8'h0C, 32'h0000_0000);
    chk("bad_wresp", r, RESP_SLVERR);
  endtask : t_regs
  task t_write;
    axw(REG_CTRL, 32'h0000_0104);
    amp <= 1'b1;
    wr_en <= 1'b1;
    repeat (48) @(posedge aclk);
    axr(REG_STATUS);
    chk("wr_mode", d[1:0], RWC_WRITE);
    chk("wr_right", {ho.write_right, ho.write_left}, 32'h2);
    chk("wr_tap", ho.ct_sel, 32'h4);
    // All ones: exactly one mid-cell transition per cell.
    n = 0;
    repeat (64) begin
      c = ho.write_coil;
      @(posedge aclk);
      if (ho.write_coil !== c) n++;
    end
    chk("coil_flips", 32'(n), 32'h8);
    axw(REG_CTRL, 32'h0000_0304);
    repeat (4) @(posedge aclk);
    chk("defeat_tap", ho.ct_sel, 32'h0);
    wr_en <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : t_write
  task t_read;
    axw(REG_CTRL, 32'h0000_0103);
    amp <= 1'b0;
    rd_en <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("rd_noamp", co.rd_strobe, 32'h0);
    amp <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("rd_left", {ho.read_left, ho.read_right}, 32'h2);
    chk("rd_tap", ho.ct_sel, 32'h2);
    n = 0;
    m = 0;
    repeat (72) begin
      @(posedge aclk);
      if (co.rd_strobe === 1'b1) n++;
      if (co.rd_data === 1'b1) m++;
    end
    chk("rd_strobes", 32'(n), 32'd36);
    // Nine cells of eight cycles carry three set bits, each standing for one whole cell.
    chk("rd_ones", 32'(m), 32'd24);
    rd_en <= 1'b0;
    repeat (8) @(posedge aclk);
    n = 0;
    repeat (16) begin
      @(posedge aclk);
      if (co.rd_strobe !== 1'b0 || co.rd_data !== 1'b0) n++;
    end
    chk("rd_quiet", 32'(n), 32'h0);
  endtask : t_read
  task t_inop;
    wr_en <= 1'b1;
    rd_en <= 1'b1;
    repeat (12) @(posedge aclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (8) @(posedge aclk);
    axr(REG_STATUS);
    chk("inop_set", d[STAT_INOP], 32'h1);
    chk("inop_idle", d[1:0], RWC_IDLE);
    axw(REG_CTRL, 32'h0001_0103);
    axr(REG_STATUS);
    chk("inop_clr", d[STAT_INOP], 32'h0);
  endtask : t_inop
  task give_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdy <= 1'b1;
    @(posedge aclk);
    chk("servo_tap", ho.servo_ct, 32'h1);
    t_servo();
    t_regs();
    t_write();
    t_read();
    t_inop();
    give_verdict();
  end
endmodule : tb_rwc_channel
`default_nettype wire
